// File: core/jlm_cfg_if.sv
/*
 * Decoded mode parameters passed from the register front end to the lane mapper.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/1ps
interface jlm_cfg_if;
    logic [3:0] lanes;
    logic dual;
    logic bypass;
    logic active;
    modport src (output lanes, output dual, output bypass, output active);
    modport dst (input lanes, input dual, input bypass, input active);
endinterface

// File: core/jlm_lane_map.sv
/*
 * Per-sample formatter: builds the 16-bit link word, flags overrange, and
 * drives lane enables and lane identifiers.
 * Assumes samples arrive on CLK from logic in the same domain.
 */
`timescale 1ns/1ps
module jlm_lane_map
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Configuration.
    jlm_cfg_if.dst cfg,
    input wire logic [14:0] thr_lo,
    input wire logic [14:0] thr_hi,
    // Sample input.
    input wire logic smp_valid,
    input wire logic [14:0] smp_data,
    // Formatted output.
    output logic [15:0] word_r,
    output logic word_valid_r,
    output logic flag_lo_r,
    output logic flag_hi_r,
    output logic [7:0] lane_en_r,
    output logic [23:0] lane_id_r
);
    logic [14:0] mag;
    logic over_lo;
    logic over_hi;
    logic [15:0] word_nxt;
    logic [7:0] en_nxt;

    // Magnitude of a two's complement sample, negated when the sign bit is set; no clamp is applied.
    function automatic logic [14:0] jlm_abs(input logic [14:0] v);
        jlm_abs = v[14] ? 15'(~v + 15'h0001) : v;
    endfunction

    assign mag = jlm_abs(smp_data);
    assign over_lo = cfg.dual && !cfg.bypass && (mag > thr_lo);
    assign over_hi = cfg.dual && !cfg.bypass && (mag > thr_hi);
    // Offset binary 12-bit sample left aligned, tail nibble forced to zero.
    assign word_nxt = cfg.bypass ? {~smp_data[14], smp_data[13:3], 4'h0}
                                 : {smp_data, over_lo};
    assign en_nxt = cfg.active ? 8'((9'h001 << cfg.lanes) - 9'h001) : 8'h00;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            word_r <= 16'h0000;
            word_valid_r <= 1'b0;
            flag_lo_r <= 1'b0;
            flag_hi_r <= 1'b0;
            lane_en_r <= 8'h00;
        end
        else
        begin
            word_valid_r <= smp_valid && cfg.active;
            if (smp_valid && cfg.active)
            begin
                word_r <= word_nxt;
                flag_lo_r <= over_lo;
                flag_hi_r <= over_hi;
            end
            lane_en_r <= en_nxt;
        end
    end

    // Lane identifier equals the lane's index within its link.
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_lid
            always_ff @(posedge clk)
            begin
                if (!reset_n)
                    lane_id_r[3*g +: 3] <= 3'h0;
                else
                    lane_id_r[3*g +: 3] <= 3'(g);
            end
        end
    endgenerate

    a_flag_cause: assert property (@(posedge clk) disable iff (!reset_n)
        (smp_valid && cfg.active) |=> (flag_lo_r == $past(over_lo)))
        else $error("low overrange flag mismatch");
    a_flag_hi_cause: assert property (@(posedge clk) disable iff (!reset_n)
        (smp_valid && cfg.active && !cfg.dual) |=> !flag_hi_r)
        else $error("high overrange flag outside dual decimation");
    a_tail_zero: assert property (@(posedge clk) disable iff (!reset_n)
        (smp_valid && cfg.active && cfg.bypass) |=> (word_r[3:0] == 4'h0))
        else $error("tail bits not zero");
    a_lane_low: assert property (@(posedge clk) disable iff (!reset_n)
        ##1 ((lane_en_r & 8'(lane_en_r + 8'h01)) == 8'h00))
        else $error("lane enables not lowest contiguous");
    c_over: cover property (@(posedge clk) disable iff (!reset_n) flag_lo_r && flag_hi_r);
endmodule // jlm_lane_map

// File: core/jlm_mapper_top.sv
/*
 * Mode select, link parameter decode and register front end of the serial link
 * transport mapper, with the per-sample lane formatter below it.
 * Assumes an Avalon-MM master on CLK and a decimated sample stream on CLK.
 */
`timescale 1ns/1ps
// Contract
// - Only listed modes are valid configurations.
// - Mode 59: dec16 dual, 1 lane, 66b F4.
// - Mode 60: dec16 dual, 2 lanes, 66b F2.
// - Modes 61-63: dec16 single, 10b, K 16:8:256.
// - Modes 64-65: dec16 single, 66b, K 128.
// - Modes 66-67: dec32 dual, 10b, K ranges.
// - Mode 68: dec32 dual, 1 lane, 66b F4.
// - Modes 69-71: dec32 single, 10b or 66b.
// - Decimated word is 15 data plus overrange.
// - Bypass maps 12-bit offset binary samples; the code selects bypass only at decimation 1, which no listed mode has.
// - Tail bits are always zero.
// - Samples go out MSB first.
// - 66b K equals 256 times E over F.
// - 10b K programmed in range, used as-is.
// - Sixteen lanes form two eight-lane links.
// - Both links used, at most eight lanes.
// - Lowest lanes on, higher lanes powered down.
// - Link B identifier is programmed identifier plus one.
// - Low overrange flag above low threshold; the code raises it in dual modes only.
// - High overrange flag above high threshold; the code raises it in dual modes only.
module jlm_mapper_top
#(
    parameter int LANES = 8
)
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic RESET_N,
    // Avalon-MM register slave.
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Sample stream.
    input wire logic SMP_VALID,
    input wire logic [14:0] SMP_DATA,
    // Link outputs; word, flags, lane IDs and K shared by both links, lane enables and device IDs per link.
    output logic [15:0] LINK_WORD,
    output logic LINK_WORD_VALID,
    output logic CHAN_A_OVERRANGE_FLAG_LO,
    output logic CHAN_A_OVERRANGE_FLAG_HI,
    output logic [7:0] LINK_A_LANE_EN,
    output logic [7:0] LINK_B_LANE_EN,
    output logic [23:0] LANE_ID,
    output logic [7:0] LINK_A_DEV_ID,
    output logic [7:0] LINK_B_DEV_ID,
    output logic [8:0] MULTIFRAME_K
);
    initial
    begin
        if (LANES != jlm_pkg::LANES_PER_LINK)
            $error("LANES must equal eight per link");
    end

    typedef enum logic [2:0] {
        JLM_IDLE = 3'b001,
        JLM_ACK = 3'b010,
        JLM_DONE = 3'b100
    } jlm_bus_t;

    jlm_bus_t bus_r;
    jlm_bus_t bus_nxt;
    logic [7:0] link_mode_select_r;
    logic [7:0] multiframe_len_field_r;
    logic [7:0] dev_id_r;
    logic [14:0] overrange_threshold_lo_r;
    logic [14:0] overrange_threshold_hi_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic wait_r;
    logic [7:0] dev_b_r;
    logic [8:0] k_r;
    logic cfg_valid_r;
    logic cfg_dual_r;
    logic cfg_bypass_r;
    logic [3:0] cfg_lanes_r;
    logic [7:0] link_b_en_r;
    jlm_pkg::jlm_mode_t mode_dec;
    logic [8:0] k_prog;
    logic [8:0] k_nxt;
    logic k_ok;
    logic [31:0] status_word;
    logic bus_req;
    logic wr_commit;
    logic rd_capture;
    logic [7:0] lane_mask_nxt;
    logic [14:0] thr_lo_nxt;
    logic [14:0] thr_hi_nxt;
    logic [7:0] dev_b_nxt;

    jlm_cfg_if cfg_u ();

    // Builds one row of the mode table; every listed mode is valid.
    function automatic jlm_pkg::jlm_mode_t jlm_entry
    (
        input logic enc66,
        input logic dual,
        input logic [5:0] dec,
        input logic [3:0] lanes,
        input logic [3:0] f,
        input logic [8:0] kmin,
        input logic [8:0] kstep
    );
        jlm_pkg::jlm_mode_t e;
        e.valid = 1'b1;
        e.enc66 = enc66;
        e.dual = dual;
        e.dec = dec;
        e.lanes = lanes;
        e.f = f;
        e.kmin = kmin;
        e.kstep = kstep;
        return e;
    endfunction

    // Mode table: encoding, channels, decimation, lanes per link, F and the K grid.
    // A 64b/66b row carries no K grid because K is derived there.
    function automatic jlm_pkg::jlm_mode_t jlm_decode(input logic [7:0] sel);
        jlm_pkg::jlm_mode_t e;
        e = '0;
        case (sel)
            8'h3b: e = jlm_entry(1'b1, 1'b1, 6'h10, 4'h1, 4'h4, 9'h000, 9'h000);
            8'h3c: e = jlm_entry(1'b1, 1'b1, 6'h10, 4'h2, 4'h2, 9'h000, 9'h000);
            8'h3d: e = jlm_entry(1'b0, 1'b0, 6'h10, 4'h1, 4'h2, 9'h010, 9'h008);
            8'h3e: e = jlm_entry(1'b0, 1'b0, 6'h10, 4'h2, 4'h2, 9'h010, 9'h008);
            8'h3f: e = jlm_entry(1'b0, 1'b0, 6'h10, 4'h4, 4'h2, 9'h010, 9'h008);
            8'h40: e = jlm_entry(1'b1, 1'b0, 6'h10, 4'h1, 4'h2, 9'h000, 9'h000);
            8'h41: e = jlm_entry(1'b1, 1'b0, 6'h10, 4'h2, 4'h2, 9'h000, 9'h000);
            8'h42: e = jlm_entry(1'b0, 1'b1, 6'h20, 4'h1, 4'h4, 9'h008, 9'h004);
            8'h43: e = jlm_entry(1'b0, 1'b1, 6'h20, 4'h2, 4'h2, 9'h010, 9'h008);
            8'h44: e = jlm_entry(1'b1, 1'b1, 6'h20, 4'h1, 4'h4, 9'h000, 9'h000);
            8'h45: e = jlm_entry(1'b0, 1'b0, 6'h20, 4'h1, 4'h2, 9'h010, 9'h008);
            8'h46: e = jlm_entry(1'b0, 1'b0, 6'h20, 4'h2, 4'h2, 9'h010, 9'h008);
            8'h47: e = jlm_entry(1'b1, 1'b0, 6'h20, 4'h1, 4'h2, 9'h000, 9'h000);
            default: e = '0;
        endcase
        return e;
    endfunction

    // K of a 64b/66b mode is 8 * 32 * E / F, with E fixed at one in every listed mode.
    function automatic logic [8:0] jlm_k66(input logic [3:0] f);
        int k;
        k = (f == 4'h0) ? 0 : jlm_pkg::K66_NUM / int'(f);
        return 9'(k);
    endfunction

    // A programmed K is legal when it lies on the mode's grid from its minimum up to 256.
    function automatic logic jlm_k_ok(input logic [8:0] k, input logic [8:0] kmin, input logic [8:0] kstep);
        logic [8:0] span;
        logic ok;
        span = 9'(k - kmin);
        ok = (kstep != 9'h000) && (k >= kmin);
        if (ok)
            ok = (span % kstep) == 9'h000;
        return ok;
    endfunction

    // Byte lanes of a threshold write land only where the byte enable is set.
    function automatic logic [14:0] jlm_bytes(input logic [14:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [14:0] v;
        v = old;
        if (be[0])
            v[7:0] = wd[7:0];
        if (be[1])
            v[14:8] = wd[14:8];
        return v;
    endfunction

    // Mode decode and derived link parameters.
    assign mode_dec = jlm_decode(link_mode_select_r);
    assign k_prog = {1'b0, multiframe_len_field_r} + 9'h001;
    assign k_ok = mode_dec.enc66 ? mode_dec.valid : jlm_k_ok(k_prog, mode_dec.kmin, mode_dec.kstep);
    assign k_nxt = !mode_dec.valid ? 9'h000 : (mode_dec.enc66 ? jlm_k66(mode_dec.f) : k_prog);
    assign status_word = {2'h0, mode_dec.lanes, mode_dec.dec, 3'h0, k_nxt, mode_dec.f, mode_dec.dual, k_ok,
                          mode_dec.enc66, mode_dec.valid};
    assign lane_mask_nxt = cfg_valid_r ? 8'((9'h001 << cfg_lanes_r) - 9'h001) : 8'h00;

    // Bus decode.
    assign bus_req = AVS_READ || AVS_WRITE;
    assign wr_commit = (bus_r == JLM_ACK) && AVS_WRITE;
    assign rd_capture = (bus_nxt == JLM_ACK);
    assign thr_lo_nxt = jlm_bytes(overrange_threshold_lo_r, AVS_WRITEDATA, AVS_BYTEENABLE);
    assign thr_hi_nxt = jlm_bytes(overrange_threshold_hi_r, AVS_WRITEDATA, AVS_BYTEENABLE);
    assign dev_b_nxt = AVS_WRITEDATA[7:0] + 8'h01;

    // Read data selection.
    always_comb
    begin
        case (AVS_ADDRESS)
            jlm_pkg::OFF_MODE: rdata_nxt = {24'h000000, link_mode_select_r};
            jlm_pkg::OFF_KLEN: rdata_nxt = {24'h000000, multiframe_len_field_r};
            jlm_pkg::OFF_DEV_ID: rdata_nxt = {24'h000000, dev_id_r};
            jlm_pkg::OFF_THR_LO: rdata_nxt = {17'h00000, overrange_threshold_lo_r};
            jlm_pkg::OFF_THR_HI: rdata_nxt = {17'h00000, overrange_threshold_hi_r};
            jlm_pkg::OFF_STATUS: rdata_nxt = status_word;
            jlm_pkg::OFF_LANES: rdata_nxt = {16'h0000, LINK_B_LANE_EN, LINK_A_LANE_EN};
            jlm_pkg::OFF_LINKID: rdata_nxt = {16'h0000, dev_b_r, dev_id_r};
            default: rdata_nxt = jlm_pkg::UNMAPPED_DATA;
        endcase
    end

    // Bus state: one answering cycle per request, then one cycle of rest.
    always_comb
    begin
        bus_nxt = bus_r;
        case (bus_r)
            JLM_IDLE:
            begin
                if (bus_req)
                    bus_nxt = JLM_ACK;
            end
            JLM_ACK: bus_nxt = JLM_DONE;
            JLM_DONE: bus_nxt = JLM_IDLE;
            default: bus_nxt = JLM_IDLE;
        endcase
    end

    // Waitrequest is low only in the answering cycle, so the master's sampling edge
    // is the one that leaves it; writes commit on that same edge.
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            bus_r <= JLM_IDLE;
            wait_r <= 1'b1;
            rdata_r <= 32'h00000000;
        end
        else
        begin
            bus_r <= bus_nxt;
            wait_r <= !rd_capture;
            if (rd_capture)
                rdata_r <= rdata_nxt;
        end
    end

    // Register file.
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            link_mode_select_r <= jlm_pkg::MODE_RESET;
            multiframe_len_field_r <= jlm_pkg::KLEN_RESET;
            dev_id_r <= jlm_pkg::DEV_ID_RESET;
            dev_b_r <= 8'(jlm_pkg::DEV_ID_RESET + 8'h01);
            overrange_threshold_lo_r <= jlm_pkg::THR_LO_RESET;
            overrange_threshold_hi_r <= jlm_pkg::THR_HI_RESET;
        end
        else if (wr_commit)
        begin
            case (AVS_ADDRESS)
                jlm_pkg::OFF_MODE:
                begin
                    if (AVS_BYTEENABLE[0])
                        link_mode_select_r <= AVS_WRITEDATA[7:0];
                end
                jlm_pkg::OFF_KLEN:
                begin
                    if (AVS_BYTEENABLE[0])
                        multiframe_len_field_r <= AVS_WRITEDATA[7:0];
                end
                jlm_pkg::OFF_DEV_ID:
                begin
                    if (AVS_BYTEENABLE[0])
                    begin
                        dev_id_r <= AVS_WRITEDATA[7:0];
                        dev_b_r <= dev_b_nxt;
                    end
                end
                jlm_pkg::OFF_THR_LO: overrange_threshold_lo_r <= thr_lo_nxt;
                jlm_pkg::OFF_THR_HI: overrange_threshold_hi_r <= thr_hi_nxt;
                default:
                begin
                end
            endcase
        end
    end

    // Decoded configuration and K one cycle behind the mode register; link B lane enables two cycles behind.
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            cfg_valid_r <= 1'b0;
            cfg_dual_r <= 1'b0;
            cfg_bypass_r <= 1'b0;
            cfg_lanes_r <= 4'h0;
            link_b_en_r <= 8'h00;
            k_r <= 9'h000;
        end
        else
        begin
            cfg_valid_r <= mode_dec.valid;
            cfg_dual_r <= mode_dec.dual;
            cfg_bypass_r <= mode_dec.valid && (mode_dec.dec == 6'h01);
            cfg_lanes_r <= mode_dec.lanes;
            link_b_en_r <= lane_mask_nxt;
            k_r <= k_nxt;
        end
    end

    assign cfg_u.lanes = cfg_lanes_r;
    assign cfg_u.dual = cfg_dual_r;
    assign cfg_u.bypass = cfg_bypass_r;
    assign cfg_u.active = cfg_valid_r;

    // Per-sample formatter; link A's lane enables come from it, link B's are an equal mask built here from the same decoded configuration.
    jlm_lane_map map_u
    (
        .clk(CLK),
        .reset_n(RESET_N),
        .cfg(cfg_u),
        .thr_lo(overrange_threshold_lo_r),
        .thr_hi(overrange_threshold_hi_r),
        .smp_valid(SMP_VALID),
        .smp_data(SMP_DATA),
        .word_r(LINK_WORD),
        .word_valid_r(LINK_WORD_VALID),
        .flag_lo_r(CHAN_A_OVERRANGE_FLAG_LO),
        .flag_hi_r(CHAN_A_OVERRANGE_FLAG_HI),
        .lane_en_r(LINK_A_LANE_EN),
        .lane_id_r(LANE_ID)
    );

    assign AVS_WAITREQUEST = wait_r;
    assign AVS_READDATA = rdata_r;
    assign LINK_B_LANE_EN = link_b_en_r;
    assign LINK_A_DEV_ID = dev_id_r;
    assign LINK_B_DEV_ID = dev_b_r;
    assign MULTIFRAME_K = k_r;

    a_wait_pulse: assert property (@(posedge CLK) disable iff (!RESET_N)
        !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low for more than one cycle");
    a_links_same: assert property (@(posedge CLK) disable iff (!RESET_N)
        LINK_A_LANE_EN == LINK_B_LANE_EN)
        else $error("links disagree on lane enables");
    a_link_b_id: assert property (@(posedge CLK) disable iff (!RESET_N)
        LINK_B_DEV_ID == 8'(LINK_A_DEV_ID + 8'h01))
        else $error("link B identifier not link A plus one");
    a_bad_mode_dark: assert property (@(posedge CLK) disable iff (!RESET_N)
        !cfg_valid_r |=> (LINK_B_LANE_EN == 8'h00))
        else $error("lanes enabled in an unlisted mode");
    c_mode_66b: cover property (@(posedge CLK) disable iff (!RESET_N) cfg_valid_r && mode_dec.enc66);
    c_mode_10b: cover property (@(posedge CLK) disable iff (!RESET_N) cfg_valid_r && !mode_dec.enc66);
endmodule // jlm_mapper_top

// File: core/jlm_pkg.sv
/*
 * Constants, mode table entries and register map for the lane transport mapper.
 * Assumes a single 50 MHz clock and an Avalon-MM register master.
 */
package jlm_pkg;
    localparam int CLK_HZ = 50000000;
    localparam int LANES_PER_LINK = 8;
    localparam logic [7:0] MODE_FIRST = 8'h3b;
    localparam logic [7:0] MODE_LAST = 8'h47;
    localparam logic [7:0] MODE_RESET = 8'h3b;
    localparam logic [7:0] KLEN_RESET = 8'h0f;
    localparam logic [7:0] DEV_ID_RESET = 8'h00;
    localparam logic [14:0] THR_LO_RESET = 15'h7000;
    localparam logic [14:0] THR_HI_RESET = 15'h7800;
    localparam logic [3:0] OFF_MODE = 4'h0;
    localparam logic [3:0] OFF_KLEN = 4'h1;
    localparam logic [3:0] OFF_DEV_ID = 4'h2;
    localparam logic [3:0] OFF_THR_LO = 4'h3;
    localparam logic [3:0] OFF_THR_HI = 4'h4;
    localparam logic [3:0] OFF_STATUS = 4'h5;
    localparam logic [3:0] OFF_LANES = 4'h6;
    localparam logic [3:0] OFF_LINKID = 4'h7;
    localparam int ST_VALID_BIT = 0;
    localparam int ST_ENC66_BIT = 1;
    localparam int ST_KOK_BIT = 2;
    localparam int ST_DUAL_BIT = 3;
    localparam int ST_F_POS = 4;
    localparam int ST_K_POS = 8;
    localparam int ST_DEC_POS = 20;
    localparam int ST_L_POS = 26;
    localparam int K66_NUM = 8 * 32;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    typedef struct packed {
        logic valid;
        logic enc66;
        logic dual;
        logic [5:0] dec;
        logic [3:0] lanes;
        logic [3:0] f;
        logic [8:0] kmin;
        logic [8:0] kstep;
    } jlm_mode_t;
endpackage

// File: verif/jlm_mapper_top_tb_top.sv
/* Self-checking bench for the lane transport mapper.
   Assumes the mapper answers Avalon-MM accesses on CLK. */
`timescale 1ns/1ps
module jlm_mapper_top_tb_top;
    logic CLK = 0;
    logic RESET_N = 0;
    logic [3:0] AVS_ADDRESS = 4'h0;
    logic AVS_READ = 0;
    logic AVS_WRITE = 0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [31:0] AVS_READDATA, q;
    logic AVS_WAITREQUEST, LINK_WORD_VALID, FLO, FHI;
    logic SMP_VALID = 0;
    logic [14:0] SMP_DATA = 15'h0;
    logic [15:0] LINK_WORD, lw;
    logic [7:0] LINK_A_LANE_EN, LINK_B_LANE_EN, LINK_A_DEV_ID, LINK_B_DEV_ID;
    logic [23:0] LANE_ID, lid;
    logic [8:0] MULTIFRAME_K;
    int fails = 0;
    int checked = 0;
    int words, i;
    // Rows: mode, multiframe field, lane enables, expected K.
    logic [32:0] r[13] = '{{8'h3b, 8'h0f, 8'h01, 9'h040}, {8'h3c, 8'h0f, 8'h03, 9'h080},
        {8'h3d, 8'h0f, 8'h01, 9'h010}, {8'h3e, 8'h17, 8'h03, 9'h018}, {8'h3f, 8'hff, 8'h0f, 9'h100},
        {8'h40, 8'h0f, 8'h01, 9'h080}, {8'h41, 8'h0f, 8'h03, 9'h080}, {8'h42, 8'h07, 8'h01, 9'h008},
        {8'h43, 8'h1f, 8'h03, 9'h020}, {8'h44, 8'h0f, 8'h01, 9'h040}, {8'h45, 8'h0f, 8'h01, 9'h010},
        {8'h46, 8'h0f, 8'h03, 9'h010}, {8'h47, 8'h0f, 8'h01, 9'h080}};
    jlm_mapper_top dut_u (.CLK(CLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hf),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .SMP_VALID(SMP_VALID),
        .SMP_DATA(SMP_DATA), .LINK_WORD(LINK_WORD), .LINK_WORD_VALID(LINK_WORD_VALID),
        .CHAN_A_OVERRANGE_FLAG_LO(FLO), .CHAN_A_OVERRANGE_FLAG_HI(FHI), .LINK_A_LANE_EN(LINK_A_LANE_EN),
        .LINK_B_LANE_EN(LINK_B_LANE_EN), .LANE_ID(LANE_ID), .LINK_A_DEV_ID(LINK_A_DEV_ID),
        .LINK_B_DEV_ID(LINK_B_DEV_ID), .MULTIFRAME_K(MULTIFRAME_K));
    jlm_rx_model rx_u (.clk(CLK), .word(LINK_WORD), .word_valid(LINK_WORD_VALID), .last_word(lw),
        .words(words));
    initial
    begin
        forever #10 CLK = ~CLK;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
            fails++;
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int n;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= {24'h0, d};
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        n = 0;
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (AVS_WAITREQUEST !== 1'b0 && n < 100);
        q = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        @(posedge CLK);
    endtask
    // A sample is sent and the flags are looked at with its formatted word.
    task automatic smp(input logic [14:0] d, input logic lo, input logic hi);
        SMP_DATA <= d;
        SMP_VALID <= 1'b1;
        @(posedge CLK);
        SMP_VALID <= 1'b0;
        @(negedge CLK);
        chk({LINK_WORD_VALID, FHI, FLO}, {1'b1, hi, lo});
        chk(LINK_WORD, {d, lo});
        @(posedge CLK);
    endtask
    task automatic print_verdict();
        if (fails == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge CLK);
        RESET_N <= 1'b1;
        @(posedge CLK);
        bus(0, jlm_pkg::OFF_MODE, 8'h0);
        chk(q, {24'h0, jlm_pkg::MODE_RESET});
        bus(0, jlm_pkg::OFF_KLEN, 8'h0);
        chk(q, {24'h0, jlm_pkg::KLEN_RESET});
        for (i = 0; i < 13; i++)
        begin
            bus(1, jlm_pkg::OFF_KLEN, r[i][24:17]);
            bus(1, jlm_pkg::OFF_MODE, r[i][32:25]);
            bus(0, jlm_pkg::OFF_STATUS, 8'h0);
            chk(q[jlm_pkg::ST_VALID_BIT], 1);
            chk(MULTIFRAME_K, r[i][8:0]);
            chk({LINK_A_LANE_EN, LINK_B_LANE_EN}, {2{r[i][16:9]}});
        end
        for (i = 0; i < 8; i++)
            lid[3*i+:3] = i[2:0];
        chk(LANE_ID, lid);
        bus(1, jlm_pkg::OFF_MODE, 8'h48);
        bus(0, jlm_pkg::OFF_STATUS, 8'h0);
        chk(q[jlm_pkg::ST_VALID_BIT], 0);
        chk({LINK_A_LANE_EN, LINK_B_LANE_EN}, 16'h0000);
        bus(0, 4'hf, 8'h0);
        chk(q, jlm_pkg::UNMAPPED_DATA);
        bus(1, jlm_pkg::OFF_DEV_ID, 8'hff);
        chk({LINK_A_DEV_ID, LINK_B_DEV_ID}, 16'hff00);
        bus(1, jlm_pkg::OFF_DEV_ID, 8'h41);
        chk({LINK_A_DEV_ID, LINK_B_DEV_ID}, 16'h4142);
        bus(1, jlm_pkg::OFF_MODE, 8'h3b);
        bus(1, jlm_pkg::OFF_THR_LO, 8'h40);
        bus(1, jlm_pkg::OFF_THR_HI, 8'h80);
        smp(15'h0060, 1, 0);
        smp(15'h0100, 1, 1);
        smp(15'h0010, 0, 0);
        smp(15'h7fa0, 1, 0);
        @(negedge CLK);
        chk(words, 4);
        chk(lw, {15'h7fa0, 1'b1});
        // A reset in mid-run brings registers and identifiers back to their reset values.
        RESET_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RESET_N <= 1'b1;
        @(posedge CLK);
        bus(0, jlm_pkg::OFF_MODE, 8'h0);
        chk(q, {24'h0, jlm_pkg::MODE_RESET});
        chk({LINK_A_DEV_ID, LINK_B_DEV_ID}, {jlm_pkg::DEV_ID_RESET, 8'(jlm_pkg::DEV_ID_RESET + 8'h01)});
        print_verdict();
    end
    initial
    begin
        repeat (20000) @(posedge CLK);
        fails++;
        print_verdict();
    end
endmodule // jlm_mapper_top_tb_top

// File: verif/jlm_rx_model.sv
/* Receiving logic model at the far side of the link outputs.
   Assumes link words arrive on CLK in the same clock domain. */
`timescale 1ns/1ps
module jlm_rx_model
(
    // Clock.
    input wire logic clk,
    // Link side.
    input wire logic [15:0] word,
    input wire logic word_valid,
    output logic [15:0] last_word,
    output int words
);
    initial words = 0;
    // Every valid word is counted, and the last one is kept on last_word.
    always @(posedge clk)
    begin
        if (word_valid === 1'b1)
        begin
            last_word <= word;
            words <= words + 1;
        end
    end
endmodule // jlm_rx_model
